// File: hdl/thermal_monitor_control.sv
// thermal monitor control: power gating, threshold sensing, flags and shutdown
// How it works
// R1: each threshold comparison is debounced 10 us in both directions before sense changes.
// R2: sampling mode powers the monitor 450 us every 3.0 ms, evaluating only then.
// R3: in Run, always-on select 1 keeps monitor powered; 0 uses sampling mode.
// R4: monitor enable 0 turns all monitoring off; 1 turns it on.
// R5: in Standby, an enabled monitor only samples, ignoring always-on select.
// R6: a threshold crossing sets that threshold's interrupt flag.
// R7: six thresholds at 80 to 155 degC, each with flag, sense and mask.
// R8: a sense bit releases only once temperature is 5 degC below its threshold.
// R9: shutdown threshold trips shutdown, held until cooled by the shutdown hysteresis.
// R10: flags latch until written 1 to clear; a set mask blocks the interrupt.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module thermal_monitor_control #(
  parameter int unsigned SAMPLE_INTERVAL_CYC = thermal_pkg::SAMPLE_INTERVAL_CYC,
  parameter int unsigned SAMPLE_WINDOW_CYC   = thermal_pkg::SAMPLE_WINDOW_CYC,
  parameter int unsigned DEBOUNCE_CYC        = thermal_pkg::DEBOUNCE_CYC
) (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [thermal_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [31:0]                    wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  output logic      [1:0]                     bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  input  wire logic [thermal_pkg::ADDR_W-1:0] araddr,
  input  wire logic                           arvalid,
  output logic                                arready,
  output logic      [31:0]                    rdata,
  output logic      [1:0]                     rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  input  wire logic                           standby_state,
  input  wire logic [7:0]                     temp_degc,
  output logic                                monitor_power,
  output logic                                thermal_shutdown,
  output logic                                irq
);
  // widths of the threshold set, the event vector and the phase counter
  localparam int unsigned N  = thermal_pkg::N_THRESH;
  localparam int unsigned NE = thermal_pkg::N_EVT;
  localparam int unsigned PW = $clog2(SAMPLE_INTERVAL_CYC);

  // carrier between the bus front end and the registers
  reg_if rif ();

  // bus front end
  axi_lite_slave u_bus (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .awaddr     (awaddr),
    .awvalid    (awvalid),
    .awready    (awready),
    .wdata      (wdata),
    .wstrb      (wstrb),
    .wvalid     (wvalid),
    .wready     (wready),
    .bresp_reg  (bresp),
    .bvalid_reg (bvalid),
    .bready     (bready),
    .araddr     (araddr),
    .arvalid    (arvalid),
    .arready    (arready),
    .rdata_reg  (rdata),
    .rresp_reg  (rresp),
    .rvalid_reg (rvalid),
    .rready     (rready),
    .rif        (rif)
  );

  // trip level: lowered by the hysteresis while the sense is already held
  function automatic logic [7:0] trip_level(input logic [7:0] thr, input logic [7:0] hys, input logic held);
    trip_level = held ? 8'(thr - hys) : thr;
  endfunction

  // control and status registers
  logic [1:0]    ctrl_reg;
  logic [1:0]    ctrl_next;
  logic [NE-1:0] mask_reg;
  logic [NE-1:0] mask_next;
  logic [NE-1:0] flag_reg;
  logic [NE-1:0] flag_next;
  logic          irq_reg;
  logic          irq_next;
  logic [NE-1:0] stable;
  logic [NE-1:0] changed;
  logic [NE-1:0] raw;
  logic [NE-1:0] events;
  logic [NE-1:0] clr_bits;
  logic          wr_ctrl;
  logic          wr_clear;
  logic          wr_mask;
  logic          lane0;
  logic          mon_en;
  logic          aon_run;

  assign mon_en  = ctrl_reg[thermal_pkg::CTRL_EN_BIT];
  // an enabled monitor in standby always samples, whatever the always-on select says
  assign aon_run = ctrl_reg[thermal_pkg::CTRL_AON_BIT] && !standby_state; // R3 R5

  // sampling timer and monitor power
  logic [PW-1:0] phase_reg;
  logic [PW-1:0] phase_next;
  logic          power_reg;
  logic          power_next;

  always_comb begin
    phase_next = phase_reg;
    power_next = 1'b0;
    if (!mon_en) begin
      phase_next = '0;                                       // R4
      power_next = 1'b0;                                     // R4
    end else begin
      phase_next = (phase_reg == PW'(SAMPLE_INTERVAL_CYC - 1)) ? '0 : phase_reg + PW'(1); // R2
      power_next = aon_run || (phase_next < PW'(SAMPLE_WINDOW_CYC));                        // R2 R3 R5
    end
  end

  // phase and power registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= '0;
      power_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      power_reg <= power_next;
    end
  end

  // power output straight from its register, no glitches on the analog enable
  assign monitor_power = power_reg;

  // raw comparisons; the held level gives the falling hysteresis
  always_comb begin
    for (int i = 0; i < N; i++) begin
      raw[i] = temp_degc >= trip_level(thermal_pkg::THRESH_DEGC[i], thermal_pkg::THRESH_HYST_DEGC, stable[i]); // R7 R8
    end
    raw[thermal_pkg::SD_BIT] = temp_degc >= trip_level(thermal_pkg::SHUTDOWN_DEGC,
                                 thermal_pkg::SHUTDOWN_HYST_DEGC, stable[thermal_pkg::SD_BIT]);          // R9
  end

  // evaluation only while powered, so sampling gaps freeze the senses
  threshold_debounce #(
    .W   (NE),
    .CYC (DEBOUNCE_CYC)
  ) u_debounce (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .active      (power_reg),
    .raw         (raw),
    .stable_reg  (stable),
    .changed_reg (changed)
  );

  // shutdown holds until the cooled level is debounced; nothing here is gated by it
  assign thermal_shutdown = stable[thermal_pkg::SD_BIT]; // R9

  // events: any threshold crossing, and entry into shutdown
  assign events = {changed[thermal_pkg::SD_BIT] && stable[thermal_pkg::SD_BIT], changed[N-1:0]}; // R6

  // register writes, byte lane 0 only carries bits
  assign lane0    = rif.wr_strb[0];
  assign wr_ctrl  = rif.wr_en && lane0 && rif.wr_addr == thermal_pkg::ADDR_CTRL;
  assign wr_clear = rif.wr_en && lane0 && rif.wr_addr == thermal_pkg::ADDR_IRQ_CLEAR;
  assign wr_mask  = rif.wr_en && lane0 && rif.wr_addr == thermal_pkg::ADDR_IRQ_MASK;
  assign clr_bits = wr_clear ? rif.wr_data[NE-1:0] : '0;

  always_comb begin
    ctrl_next = wr_ctrl ? rif.wr_data[1:0] : ctrl_reg;
    mask_next = wr_mask ? rif.wr_data[NE-1:0] : mask_reg;
    // a new event beats a clear in the same cycle
    flag_next = (flag_reg & ~clr_bits) | events;               // R6 R10
    irq_next  = |(flag_next & ~mask_next);                     // R10
  end

  // register state; mask resets all ones so nothing interrupts before setup
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= thermal_pkg::CTRL_RESET;
      mask_reg <= thermal_pkg::MASK_RESET;
      flag_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      flag_reg <= flag_next;
      irq_reg  <= irq_next;
    end
  end

  // interrupt straight from its register
  assign irq = irq_reg;

  // read decode; the clear register reads as zero, unmapped answers an error
  always_comb begin
    rif.rd_data = '0;
    rif.rd_err  = 1'b0;
    unique case (rif.rd_addr)
      thermal_pkg::ADDR_CTRL:       rif.rd_data = {30'h0000_0000, ctrl_reg};
      thermal_pkg::ADDR_SENSE:      rif.rd_data = {25'h000_0000, stable};
      thermal_pkg::ADDR_IRQ_STATUS: rif.rd_data = {25'h000_0000, flag_reg};
      thermal_pkg::ADDR_IRQ_CLEAR:  rif.rd_data = '0;
      thermal_pkg::ADDR_IRQ_MASK:   rif.rd_data = {25'h000_0000, mask_reg};
      default:                      rif.rd_err  = 1'b1;
    endcase
  end

  // writes outside the map answer an error
  assign rif.wr_err = !(rif.wr_addr inside {thermal_pkg::ADDR_CTRL, thermal_pkg::ADDR_SENSE,
                        thermal_pkg::ADDR_IRQ_STATUS, thermal_pkg::ADDR_IRQ_CLEAR, thermal_pkg::ADDR_IRQ_MASK});

  // helper: length of the current powered stretch in sampling mode
  logic [15:0] on_cnt_reg;
  logic [15:0] on_cnt_next;
  always_comb begin
    on_cnt_next = (!power_reg || aon_run) ? 16'h0000 : on_cnt_reg + 16'h0001;
  end

  // next value kept apart from the register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_cnt_reg <= '0;
    end else begin
      on_cnt_reg <= on_cnt_next;
    end
  end

  // power gating checks
  AST_DISABLED_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    !mon_en |=> !monitor_power)
    else $error("monitor powered while disabled");

  AST_RUN_ALWAYS_ON: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    (mon_en && aon_run) |=> monitor_power)
    else $error("always-on run mode left the monitor unpowered");

  AST_STANDBY_SAMPLES: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    (mon_en && standby_state && phase_reg == PW'(SAMPLE_WINDOW_CYC - 1)) |=> !monitor_power)
    else $error("standby kept the monitor on past the sample window");

  AST_WINDOW_LENGTH: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    monitor_power |-> on_cnt_reg < 16'(SAMPLE_WINDOW_CYC))
    else $error("sampling window exceeded its length");

  AST_SAMPLING_ON: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (mon_en && !aon_run && phase_reg < PW'(SAMPLE_WINDOW_CYC - 1)) |=> monitor_power)
    else $error("sampling window left the monitor unpowered");

  AST_STANDBY_GAP: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    (mon_en && standby_state && phase_reg >= PW'(SAMPLE_WINDOW_CYC - 1)
      && phase_reg < PW'(SAMPLE_INTERVAL_CYC - 1)) |=> !monitor_power)
    else $error("standby powered the monitor between windows");

  AST_FROZEN_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    !monitor_power |=> $stable(stable))
    else $error("sense moved while the monitor was unpowered");

  AST_EVAL_IN_WINDOW: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    !monitor_power |=> changed == '0)
    else $error("threshold evaluated outside the window");

  // flag and interrupt checks
  AST_FLAG_ON_CROSS: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    (|changed[N-1:0]) |=> (flag_reg[N-1:0] & $past(changed[N-1:0])) == $past(changed[N-1:0]))
    else $error("crossing did not set its flag");

  AST_FLAG_STICKY: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    !wr_clear |=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
    else $error("flag dropped without a clear write");

  AST_IRQ_MASKED: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    irq |-> |(flag_reg & ~mask_reg))
    else $error("interrupt raised by masked or empty flags");

  AST_IRQ_RAISED: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    |(flag_reg & ~mask_reg) |-> irq)
    else $error("unmasked flag did not raise the interrupt");

  AST_CLEAR_WORKS: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    (wr_clear && events == '0) |=> (flag_reg & $past(clr_bits)) == '0)
    else $error("clear write left a flag set");

  AST_SD_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    $rose(thermal_shutdown) |=> flag_reg[thermal_pkg::SD_BIT])
    else $error("shutdown entry did not set its flag");

  // shutdown and sense checks
  AST_SD_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    $fell(thermal_shutdown) |-> $past(temp_degc) < 8'(thermal_pkg::SHUTDOWN_DEGC - thermal_pkg::SHUTDOWN_HYST_DEGC))
    else $error("shutdown released before cooling by the hysteresis");

  for (genvar g = 0; g < N; g++) begin : g_sense_chk
    AST_SENSE_RISE: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      $rose(stable[g]) |-> $past(temp_degc) >= thermal_pkg::THRESH_DEGC[g])
      else $error("sense set below its threshold");
    AST_SENSE_FALL: assert property (@(posedge aclk) disable iff (!aresetn) // R8
      $fell(stable[g]) |-> $past(temp_degc) < 8'(thermal_pkg::THRESH_DEGC[g] - thermal_pkg::THRESH_HYST_DEGC))
      else $error("sense released inside the hysteresis band");
  end
endmodule // thermal_monitor_control

// File: hdl/thermal_pkg.sv
// constants shared by the thermal monitor control block
package thermal_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ              = 10_000_000;
  localparam int unsigned DEBOUNCE_TIME_US    = 10;    // threshold_debounce_time, least time
  localparam int unsigned DEBOUNCE_CYC        = (DEBOUNCE_TIME_US * CLK_HZ + 999_999) / 1_000_000;
  localparam real         SAMPLE_INTERVAL_MS  = 3.0;
  localparam int unsigned SAMPLE_INTERVAL_CYC = $rtoi(SAMPLE_INTERVAL_MS * CLK_HZ / 1000.0);
  localparam int unsigned SAMPLE_WINDOW_US    = 450;
  localparam int unsigned SAMPLE_WINDOW_CYC   = SAMPLE_WINDOW_US * (CLK_HZ / 1_000_000); // product kept inside 32 bits
  // thresholds in degC, index 0 is the lowest
  localparam int unsigned N_THRESH = 6;
  localparam int unsigned N_EVT    = 7;              // six thresholds plus shutdown entry
  localparam logic [N_THRESH-1:0][7:0] THRESH_DEGC = {8'h9B, 8'h8C, 8'h7D, 8'h6E, 8'h5F, 8'h50};
  localparam logic [7:0] THRESH_HYST_DEGC   = 8'h05;
  localparam logic [7:0] SHUTDOWN_DEGC      = 8'hA5; // 165 degC
  localparam logic [7:0] SHUTDOWN_HYST_DEGC = 8'h0A; // shutdown_hysteresis
  // register map, byte addresses
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_SENSE      = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_CLEAR  = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h10;
  // fields
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_AON_BIT = 1;
  localparam int unsigned SD_BIT       = 6;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam logic [6:0]  MASK_RESET   = 7'h7F;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// File: hdl/reg_if.sv
// register access carrier between the bus slave and the control core
`timescale 1ns/1ns
interface reg_if;
  logic                             wr_en;
  logic [thermal_pkg::ADDR_W-1:0]   wr_addr;
  logic [31:0]                      wr_data;
  logic [3:0]                       wr_strb;
  logic                             wr_err;
  logic [thermal_pkg::ADDR_W-1:0]   rd_addr;
  logic [31:0]                      rd_data;
  logic                             rd_err;
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_err, rd_data, rd_err);
endinterface

// File: hdl/threshold_debounce.sv
// per-bit debounce, both directions, counting only while active
`timescale 1ns/1ns
module threshold_debounce #(
  parameter int unsigned W   = 7,
  parameter int unsigned CYC = thermal_pkg::DEBOUNCE_CYC
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         active,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] stable_reg,
  output logic      [W-1:0] changed_reg
);
  localparam int unsigned CW = $clog2(CYC + 1);
  logic [W-1:0][CW-1:0] cnt_reg;
  logic [W-1:0][CW-1:0] cnt_next;
  logic [W-1:0]         stable_next;
  logic [W-1:0]         changed_next;

  // count disagreeing cycles; a glitch restarts the count
  always_comb begin
    cnt_next     = cnt_reg;
    stable_next  = stable_reg;
    changed_next = '0;
    for (int i = 0; i < W; i++) begin
      if (!active || raw[i] == stable_reg[i]) begin
        cnt_next[i] = '0;
      end else if (cnt_reg[i] == CW'(CYC - 1)) begin
        cnt_next[i]     = '0;
        stable_next[i]  = raw[i];       // R1
        changed_next[i] = 1'b1;
      end else begin
        cnt_next[i] = cnt_reg[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg     <= '0;
      stable_reg  <= '0;
      changed_reg <= '0;
    end else begin
      cnt_reg     <= cnt_next;
      stable_reg  <= stable_next;
      changed_reg <= changed_next;
    end
  end

  // helper: streak of active disagreement for bit 0
  logic [15:0] streak_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || !active || raw[0] == stable_reg[0]) begin
      streak_reg <= '0;
    end else begin
      streak_reg <= streak_reg + 16'h0001;
    end
  end

  AST_DEBOUNCE_FULL: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    $changed(stable_reg[0]) |-> $past(streak_reg) == 16'(CYC - 1))
    else $error("sense bit changed before full debounce time");
endmodule // threshold_debounce

// File: hdl/axi_lite_slave.sv
// axi4-lite slave front end, one write and one read in flight
`timescale 1ns/1ns
module axi_lite_slave (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [thermal_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [31:0]                    wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  output logic      [1:0]                     bresp_reg,
  output logic                                bvalid_reg,
  input  wire logic                           bready,
  input  wire logic [thermal_pkg::ADDR_W-1:0] araddr,
  input  wire logic                           arvalid,
  output logic                                arready,
  output logic      [31:0]                    rdata_reg,
  output logic      [1:0]                     rresp_reg,
  output logic                                rvalid_reg,
  input  wire logic                           rready,
  reg_if.bus                                  rif
);
  logic                           aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [thermal_pkg::ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0]                    wdata_reg, wdata_next;
  logic [3:0]                     wstrb_reg, wstrb_next;
  logic [1:0]                     bresp_next, rresp_next;
  logic                           bvalid_next, rvalid_next;
  logic [31:0]                    rdata_next;

  // address and data may arrive in either order
  assign awready     = !aw_hold_reg && !bvalid_reg;
  assign wready      = !w_hold_reg && !bvalid_reg;
  assign arready     = !rvalid_reg;
  assign rif.wr_en   = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rif.wr_addr = awaddr_reg;
  assign rif.wr_data = wdata_reg;
  assign rif.wr_strb = wstrb_reg;
  assign rif.rd_addr = araddr;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (awvalid && awready) begin
      aw_hold_next = 1'b1;
      awaddr_next  = awaddr;
    end
    if (wvalid && wready) begin
      w_hold_next = 1'b1;
      wdata_next  = wdata;
      wstrb_next  = wstrb;
    end
    if (rif.wr_en) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = rif.wr_err ? thermal_pkg::RESP_SLVERR : thermal_pkg::RESP_OKAY;
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rdata_next  = rif.rd_data;
      rresp_next  = rif.rd_err ? thermal_pkg::RESP_SLVERR : thermal_pkg::RESP_OKAY;
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= thermal_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= thermal_pkg::RESP_OKAY;
      rdata_reg   <= '0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end
endmodule // axi_lite_slave

// File: testbench/tb_top.sv
// self-checking bench for the thermal monitor control block
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned INTERVAL = 200;
  localparam int unsigned WINDOW   = 40;
  localparam int unsigned DEBOUNCE = 4;
  localparam int unsigned SETTLE   = DEBOUNCE + 12;

  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        standby_state;
  logic [7:0]  temp_degc;
  logic        monitor_power;
  logic        thermal_shutdown;
  logic        irq;
  int          n_mismatch;
  int          total_checks;
  logic [31:0] rd;
  logic [1:0]  rs;

  // short counts keep the run small; expectations follow these values
  thermal_monitor_control #(
    .SAMPLE_INTERVAL_CYC(INTERVAL),
    .SAMPLE_WINDOW_CYC  (WINDOW),
    .DEBOUNCE_CYC       (DEBOUNCE)
  ) u_thermal_monitor_control (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .standby_state(standby_state),
    .temp_degc(temp_degc), .monitor_power(monitor_power), .thermal_shutdown(thermal_shutdown), .irq(irq)
  );

  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // response ready held high throughout, so no same-step toggling between transfers
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rs);
    chk(what, rd, exp);
    chk("rresp", {30'h0, rs}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
    chk("bresp", {30'h0, rs}, 32'h0000_0000);
  endtask

  task automatic set_temp(input logic [7:0] t);
    temp_degc <= t;
    repeat (SETTLE) @(posedge aclk);
  endtask

  // power-on cycles over two whole intervals; phase-independent in steady state
  task automatic count_power(input string what, input int exp);
    int n;
    n = 0;
    repeat (20) @(posedge aclk);
    repeat (2 * INTERVAL) begin
      @(posedge aclk);
      if (monitor_power === 1'b1) n++;
    end
    chk(what, n, exp);
  endtask

  // a hang ends the run through the normal closing path
  initial begin
    repeat (20_000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    n_mismatch = 0;
    total_checks = 0;
    aresetn = 1'b0;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0000_0000; wstrb = 4'hF; wvalid = 1'b0;
    bready = 1'b1; araddr = 8'h00; arvalid = 1'b0; rready = 1'b1;
    standby_state = 1'b0;
    temp_degc = 8'h19;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset state and unmapped access
    rd_chk("ctrl", thermal_pkg::ADDR_CTRL, 32'h0000_0000);
    rd_chk("mask", thermal_pkg::ADDR_IRQ_MASK, 32'h0000_007F);
    rd_chk("status", thermal_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk("power off", monitor_power, 1'b0);
    axi_rd(8'h20, rd, rs);
    chk("unmapped rresp", rs, thermal_pkg::RESP_SLVERR);
    chk("unmapped rdata", rd, 32'h0000_0000);
    axi_wr(8'h20, 32'h0000_0001, rs);
    chk("unmapped bresp", rs, thermal_pkg::RESP_SLVERR);
    // always-on in run, all unmasked
    wr(thermal_pkg::ADDR_CTRL, 32'h0000_0003);
    wr(thermal_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    count_power("always on", 2 * INTERVAL);
    set_temp(8'h64);
    rd_chk("sense up", thermal_pkg::ADDR_SENSE, 32'h0000_0003);
    rd_chk("flags up", thermal_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    chk("irq set", irq, 1'b1);
    wr(thermal_pkg::ADDR_IRQ_CLEAR, 32'h0000_0003);
    rd_chk("flags cleared", thermal_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk("irq cleared", irq, 1'b0);
    // falling hysteresis, masked flag
    wr(thermal_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    set_temp(8'h5C);
    rd_chk("sense held", thermal_pkg::ADDR_SENSE, 32'h0000_0003);
    set_temp(8'h59);
    rd_chk("sense down", thermal_pkg::ADDR_SENSE, 32'h0000_0001);
    rd_chk("flag on fall", thermal_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    chk("irq masked", irq, 1'b0);
    wr(thermal_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    chk("irq unmasked", irq, 1'b1);
    wr(thermal_pkg::ADDR_IRQ_CLEAR, 32'h0000_0002);
    // glitch one cycle shorter than the debounce
    temp_degc <= 8'hAA;
    repeat (DEBOUNCE - 1) @(posedge aclk);
    set_temp(8'h59);
    rd_chk("glitch ignored", thermal_pkg::ADDR_SENSE, 32'h0000_0001);
    chk("no shutdown", thermal_shutdown, 1'b0);
    // shutdown entry and release after cooling
    set_temp(8'hAA);
    rd_chk("sense all", thermal_pkg::ADDR_SENSE, 32'h0000_007F);
    rd_chk("flags hot", thermal_pkg::ADDR_IRQ_STATUS, 32'h0000_007E);
    chk("shutdown on", thermal_shutdown, 1'b1);
    set_temp(8'h9C);
    chk("shutdown held", thermal_shutdown, 1'b1);
    set_temp(8'h9A);
    chk("shutdown released", thermal_shutdown, 1'b0);
    // sampling in run, standby overriding always-on, then disable
    wr(thermal_pkg::ADDR_CTRL, 32'h0000_0001);
    count_power("sampling run", 2 * WINDOW);
    wr(thermal_pkg::ADDR_CTRL, 32'h0000_0003);
    standby_state <= 1'b1;
    count_power("sampling standby", 2 * WINDOW);
    wr(thermal_pkg::ADDR_CTRL, 32'h0000_0000);
    count_power("disabled", 0);
    close_out();
  end
endmodule // tb_top
